/* serial_cfg_defines.vh */
// Constants for the serial channel mode and setup register bank.
// Assumes inclusion by bare name from the design files.
`ifndef SERIAL_CFG_DEFINES_VH
`define SERIAL_CFG_DEFINES_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADDR_MODE_U0C0 20'hF0108
`define ADDR_MODE_U0C1 20'hF010A
`define ADDR_SETUP_U0C0 20'hF010C
`define ADDR_SETUP_U0C1 20'hF010E
`define ADDR_MODE_U1C0 20'hF0138
`define ADDR_MODE_U1C1 20'hF013A
`define ADDR_SETUP_U1C0 20'hF013C
`define ADDR_SETUP_U1C1 20'hF013E

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MODE_RESET 16'h0020
`define SETUP_RESET 16'h0087

// ----------------------------------------
// Mode register fields
// ----------------------------------------
`define MODE_OPCLK_BIT 15
`define MODE_XFERCLK_BIT 14
`define MODE_TRIG_BIT 8
`define MODE_RXINV_BIT 6
`define MODE_PROTO_HI 2
`define MODE_PROTO_LO 1
`define MODE_IRQSRC_BIT 0
// Writable bits: 15,14,8,6,2,1,0 (bit 5 reads one)
`define MODE_WMASK 16'hC147
`define MODE_FIXED_ONES 16'h0020

// ----------------------------------------
// Setup register fields
// ----------------------------------------
`define SETUP_TXEN_BIT 15
`define SETUP_RXEN_BIT 14
`define SETUP_PAR_HI 9
`define SETUP_PAR_LO 8
`define SETUP_STOP_HI_BIT 5
`define SETUP_DLEN1_BIT 1
// Bits 11,10,6 read zero
`define SETUP_WMASK 16'hF3BF

// ----------------------------------------
// Encodings
// ----------------------------------------
`define PROTO_CSI 2'h0
`define PROTO_UART 2'h1
`define PROTO_I2C 2'h2
`define PROTO_RSVD 2'h3
`define PAR_NONE 2'h0
`define PAR_ZERO 2'h1
`define PAR_EVEN 2'h2
`define PAR_ODD 2'h3

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 50
`define DIV_BITS 7

`endif

/* serial_channel_mode_config.v */
// Mode and setup register bank for four serial channels (2 units x 2).
// Assumes a 16-bit CPU register port on the peripheral clock, and
// prescaler ticks, pins and running flags from the rest of the unit.
`timescale 1ns/1ps
`include "serial_cfg_defines.vh"

// Functional notes
// RULE_01: No mode rewrite while running, except irq select
// RULE_02: Reset loads mode register with 0020H
// RULE_03: Reset loads setup register with 0087H
// RULE_04: Bit 15 picks prescaler output for op clock
// RULE_05: Bit 14 picks divided or pin transfer clock
// RULE_06: Channel logic runs from selected transfer clock
// RULE_07: Bit 8 on unit0 chan1 picks start trigger
// RULE_08: Start only after start write and source
// RULE_09: Bit 6 unit0 chan1 UART receive polarity invert
// RULE_10: Bits 2:1 select channel protocol mode
// RULE_11: Mode 00 CSI, 01 UART, 10 I2C, 11 reserved
// RULE_12: Bit 0 selects transfer end or buffer empty irq
// RULE_13: Software uses buffer empty irq for streaming
// RULE_14: Software keeps reserved mode bits fixed
// RULE_15: No setup rewrite while channel running
// RULE_16: Setup bits 15:14 enable transmit and receive
// RULE_17: Parity field 9:8 none, zero, even, odd
// RULE_18: Parity zero outside UART mode
// RULE_19: Software keeps setup bits 6,10,11 zero
// RULE_20: Stop hi only chan0; dlen1 fixed elsewhere (code fixes dlen1 on unit1 only; unit0 chan1 keeps it writable)
// RULE_21: Prescaler write waits four clocks after gate
// RULE_22: Divide op clock by data bits plus one
// RULE_23: I2C mode uses eight-bit data length
module serial_channel_mode_config (
  input wire clock,
  input wire arst_n,
  input wire [19:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_wdata,
  output reg [15:0] reg_rdata,
  input wire [3:0] channel_running_flag,
  input wire [3:0] channel_start_pulse,
  input wire [1:0] prescaler_out_a,
  input wire [1:0] prescaler_out_b,
  input wire [27:0] data_div_bits,
  input wire [3:0] serial_clock_pin,
  input wire uart_receive_pin,
  input wire [3:0] xfer_end_event,
  input wire [3:0] buffer_load_event,
  output wire [3:0] xfer_tick,
  output wire [3:0] start_go,
  output wire [3:0] channel_irq,
  output wire [3:0] tx_enable,
  output wire [3:0] rx_enable,
  output wire [7:0] protocol_mode,
  output wire [3:0] mode_reserved,
  output wire [7:0] parity_ctrl,
  output wire rx_data_invert,
  output wire rx_edge_rise
);
  // ----------------------------------------
  // Address decode helpers
  // ----------------------------------------
  // Channel index 0..3 for an address, 4 when unmapped
  function [2:0] chan_of;
    input [19:0] a;
    begin
      case (a)
        `ADDR_MODE_U0C0, `ADDR_SETUP_U0C0: chan_of = 3'h0;
        `ADDR_MODE_U0C1, `ADDR_SETUP_U0C1: chan_of = 3'h1;
        `ADDR_MODE_U1C0, `ADDR_SETUP_U1C0: chan_of = 3'h2;
        `ADDR_MODE_U1C1, `ADDR_SETUP_U1C1: chan_of = 3'h3;
        default: chan_of = 3'h4;
      endcase
    end
  endfunction

  // True when the address names a mode register
  function is_mode;
    input [19:0] a;
    begin
      is_mode = (a == `ADDR_MODE_U0C0) || (a == `ADDR_MODE_U0C1) ||
                (a == `ADDR_MODE_U1C0) || (a == `ADDR_MODE_U1C1);
    end
  endfunction

  // Per-channel writable mask of the mode register
  function [15:0] mode_mask;
    input [1:0] ch;
    begin
      if (ch == 2'h1) begin
        mode_mask = `MODE_WMASK;
      end else begin
        // Trigger and polarity bits exist only on unit0 chan1
        mode_mask = `MODE_WMASK & 16'hFEBF;
      end
    end
  endfunction

  // Per-channel writable mask of the setup register
  function [15:0] setup_mask;
    input [1:0] ch;
    begin
      case (ch)
        2'h0: setup_mask = `SETUP_WMASK;
        2'h1: setup_mask = `SETUP_WMASK & 16'hFFDF;
        default: setup_mask = `SETUP_WMASK & 16'hFFDD;
      endcase
    end
  endfunction

  // Hard-wired setup ones per channel (dlen1 on unit1)
  function [15:0] setup_ones;
    input [1:0] ch;
    begin
      if (ch[1]) begin
        setup_ones = 16'h0002; // see RULE_20
      end else begin
        setup_ones = 16'h0000;
      end
    end
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg [3:0] sck_meta_q; // First stage, serial clock pins
  reg [3:0] sck_sync_q; // Second stage
  reg [3:0] sck_prev_q; // For rising edge detect
  reg rxd_meta_q; // First stage, receive pin
  reg rxd_sync_q; // Second stage
  reg rxd_prev_q; // For edge detect

  // Two flops on every pin input
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sck_meta_q <= 4'h0;
      sck_sync_q <= 4'h0;
      sck_prev_q <= 4'h0;
      rxd_meta_q <= 1'b1;
      rxd_sync_q <= 1'b1;
      rxd_prev_q <= 1'b1;
    end else begin
      sck_meta_q <= serial_clock_pin;
      sck_sync_q <= sck_meta_q;
      sck_prev_q <= sck_sync_q;
      rxd_meta_q <= uart_receive_pin;
      rxd_sync_q <= rxd_meta_q;
      rxd_prev_q <= rxd_sync_q;
    end
  end

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  reg [15:0] mode_q [0:3]; // Channel mode registers
  reg [15:0] setup_q [0:3]; // Channel setup registers
  wire [2:0] wr_chan; // Addressed channel
  wire wr_is_mode; // Addressed register is mode

  assign wr_chan = chan_of(reg_addr);
  assign wr_is_mode = is_mode(reg_addr);

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : chan
      wire hit; // Write targets this channel
      wire running; // Channel operating
      wire [15:0] mmask; // Writable mode bits
      wire [15:0] smask; // Writable setup bits
      wire [15:0] wmask_run; // Mode bits writable now
      wire op_tick; // Selected operating clock tick
      wire pin_tick; // Synchronised pin clock edge
      wire div_tick; // Divided operating clock tick
      wire trig_ok; // Start source satisfied
      reg armed_q; // Start written, waiting for source
      localparam [31:0] CHW = g; // Channel number as a vector

      assign hit = (wr_chan == CHW[2:0]) && reg_wr;
      assign running = channel_running_flag[g];
      assign mmask = mode_mask(CHW[1:0]);
      assign smask = setup_mask(CHW[1:0]);
      // Only irq source bit may change while running
      assign wmask_run = running ? 16'h0001 : mmask; // see RULE_01

      // Mode register write with reserved bits held
      always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          mode_q[g] <= `MODE_RESET; // see RULE_02
        end else if (hit && wr_is_mode) begin
          mode_q[g] <= (reg_wdata & wmask_run) | (mode_q[g] & ~wmask_run) |
                       `MODE_FIXED_ONES;
        end
      end

      // Setup register write, frozen while running
      always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          setup_q[g] <= `SETUP_RESET; // see RULE_03
        end else if (hit && !wr_is_mode && !running) begin // see RULE_15
          setup_q[g] <= (reg_wdata & smask) | setup_ones(CHW[1:0]); // see RULE_20
        end
      end

      // Operating clock from selected prescaler output
      assign op_tick = mode_q[g][`MODE_OPCLK_BIT] ?
                       prescaler_out_b[g/2] : prescaler_out_a[g/2]; // see RULE_04

      // Divided operating clock
      xfer_clock_divider u_div (
        .clock(clock),
        .arst_n(arst_n),
        .run(running),
        .op_tick(op_tick),
        .ratio(data_div_bits[g*7 +: 7]),
        .xfer_tick(div_tick)
      );

      assign pin_tick = sck_sync_q[g] & ~sck_prev_q[g];
      // Transfer clock that drives the channel logic
      assign xfer_tick[g] = mode_q[g][`MODE_XFERCLK_BIT] ?
                            pin_tick : div_tick; // see RULE_05, RULE_06

      // Start source: software alone, or receive pin edge
      if (g == 1) begin : trig_rx
        wire rise;
        wire fall;
        assign rise = rxd_sync_q & ~rxd_prev_q;
        assign fall = ~rxd_sync_q & rxd_prev_q;
        assign trig_ok = !mode_q[g][`MODE_TRIG_BIT] ||
                         (mode_q[g][`MODE_RXINV_BIT] ? rise : fall); // see RULE_07, RULE_09
      end else begin : trig_sw
        assign trig_ok = 1'b1;
      end

      // Arm on start write; fire when source satisfied
      always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          armed_q <= 1'b0;
        end else if (channel_start_pulse[g]) begin // New start wins over go
          armed_q <= 1'b1;
        end else if (start_go[g]) begin
          armed_q <= 1'b0;
        end else if (!running) begin
          armed_q <= 1'b0;
        end
      end
      assign start_go[g] = armed_q && trig_ok; // see RULE_08

      // Interrupt source select
      assign channel_irq[g] = mode_q[g][`MODE_IRQSRC_BIT] ?
                              buffer_load_event[g] : xfer_end_event[g]; // see RULE_12

      // Direction enables
      assign tx_enable[g] = setup_q[g][`SETUP_TXEN_BIT]; // see RULE_16
      assign rx_enable[g] = setup_q[g][`SETUP_RXEN_BIT];

      // Protocol mode field
      assign protocol_mode[g*2 +: 2] =
        mode_q[g][`MODE_PROTO_HI:`MODE_PROTO_LO]; // see RULE_10
      assign mode_reserved[g] =
        (mode_q[g][`MODE_PROTO_HI:`MODE_PROTO_LO] == `PROTO_RSVD); // see RULE_11

      // Parity only applies in UART mode
      assign parity_ctrl[g*2 +: 2] =
        (mode_q[g][`MODE_PROTO_HI:`MODE_PROTO_LO] == `PROTO_UART) ?
        setup_q[g][`SETUP_PAR_HI:`SETUP_PAR_LO] : `PAR_NONE; // see RULE_17
    end
  endgenerate

  // ----------------------------------------
  // Receive polarity (unit0 chan1 in UART mode)
  // ----------------------------------------
  assign rx_data_invert = mode_q[1][`MODE_RXINV_BIT] &&
    (mode_q[1][`MODE_PROTO_HI:`MODE_PROTO_LO] == `PROTO_UART); // see RULE_09
  assign rx_edge_rise = rx_data_invert;

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // Registered read data; unmapped reads zero
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      if (wr_chan[2]) begin
        reg_rdata <= 16'h0000;
      end else if (wr_is_mode) begin
        reg_rdata <= mode_q[wr_chan[1:0]];
      end else begin
        reg_rdata <= setup_q[wr_chan[1:0]];
      end
    end
  end
endmodule

/* serial_channel_mode_config_properties.sv */
// Checker for the serial channel mode and setup bank.
// Assumes a bind onto the bank's top module ports.
`timescale 1ns/1ps
module serial_channel_mode_config_properties (
  input wire clock,
  input wire arst_n,
  input wire [3:0] channel_running_flag,
  input wire [3:0] channel_start_pulse,
  input wire [3:0] xfer_end_event,
  input wire [3:0] buffer_load_event,
  input wire [3:0] xfer_tick,
  input wire [3:0] start_go,
  input wire [3:0] channel_irq,
  input wire [3:0] tx_enable,
  input wire [3:0] rx_enable,
  input wire [7:0] protocol_mode,
  input wire [3:0] mode_reserved,
  input wire [7:0] parity_ctrl,
  input wire rx_data_invert,
  input wire rx_edge_rise
);
  // ----
  // Defaults
  // ----
  default clocking @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  // ----
  // Properties
  // ----
  chk_reset_mode:
    assert property (disable iff (1'b0) !arst_n |-> protocol_mode == 8'h00 && !rx_data_invert)
    else $error("mode fields not cleared in reset");
  chk_reset_setup:
    assert property (disable iff (1'b0) !arst_n |-> tx_enable == 4'h0 && parity_ctrl == 8'h00)
    else $error("setup fields wrong in reset");
  chk_run_mode:
    assert property (channel_running_flag[0] |=> $stable(protocol_mode[1:0]))
    else $error("mode changed while running");
  chk_run_setup:
    assert property (channel_running_flag[0] |=> $stable(tx_enable[0]) && $stable(rx_enable[0]))
    else $error("enables changed while running");
  chk_rsvd_flag:
    assert property (mode_reserved == {&protocol_mode[7:6], &protocol_mode[5:4],
      &protocol_mode[3:2], &protocol_mode[1:0]})
    else $error("reserved flag mismatch");
  chk_par_uart:
    assert property (parity_ctrl[1:0] != 2'h0 |-> protocol_mode[1:0] == 2'h1)
    else $error("parity outside uart");
  chk_rx_invert:
    assert property (rx_edge_rise |-> rx_data_invert && protocol_mode[3:2] == 2'h1)
    else $error("receive inversion wrong");
  chk_irq_cause:
    assert property (|channel_irq |-> (channel_irq & ~(xfer_end_event | buffer_load_event)) == 0)
    else $error("irq without event");
  chk_start_soft:
    assert property (channel_start_pulse[0] && channel_running_flag[0] |=> start_go[0])
    else $error("software start missed");
  // Main scenarios reached
  cover property (start_go[0]);
  cover property (channel_irq[0]);
  cover property (xfer_tick[2]);
endmodule

/* serial_channel_mode_config_tb.sv */
// Self-checking bench for the serial channel mode and setup bank.
// Assumes the bank, its header and the checker compiled first.
`timescale 1ns/1ps
`include "serial_cfg_defines.vh"
module serial_channel_mode_config_tb;
  // ----
  // Signals
  // ----
  logic clock = 1'b0, arst_n = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rx_pin = 1'b1, seen;
  logic [19:0] reg_addr = '0;
  logic [15:0] reg_wdata = '0, d;
  logic [3:0] run = '0, start = '0, pin = '0, xend = '0, bload = '0;
  logic [1:0] pa = '0, pb = '0;
  logic [27:0] div = '0;
  wire [15:0] reg_rdata;
  wire [3:0] xt, go, irq, txe, rxe, rsv;
  wire [7:0] pm, par;
  wire inv, rise;
  int err_count = 0, num_checks = 0, r, cnt;
  // Addresses, writable masks, fixed ones
  logic [19:0] adr [8] = '{`ADDR_MODE_U0C0, `ADDR_MODE_U0C1, `ADDR_SETUP_U0C0,
    `ADDR_SETUP_U0C1, `ADDR_MODE_U1C0, `ADDR_MODE_U1C1, `ADDR_SETUP_U1C0, `ADDR_SETUP_U1C1};
  logic [15:0] wm [8] = '{16'hC007, 16'hC147, 16'hF3BF, 16'hF39F, 16'hC007, 16'hC007,
    16'hF39D, 16'hF39D};
  logic [15:0] one [8] = '{16'h0020, 16'h0020, 16'h0000, 16'h0000, 16'h0020, 16'h0020,
    16'h0002, 16'h0002};
  int rat [6] = '{0, 1, 2, 3, 5, 7};
  serial_channel_mode_config u_serial_channel_mode_config (
    .clock(clock), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .channel_running_flag(run),
    .channel_start_pulse(start), .prescaler_out_a(pa), .prescaler_out_b(pb),
    .data_div_bits(div), .serial_clock_pin(pin), .uart_receive_pin(rx_pin),
    .xfer_end_event(xend), .buffer_load_event(bload), .xfer_tick(xt), .start_go(go),
    .channel_irq(irq), .tx_enable(txe), .rx_enable(rxe), .protocol_mode(pm),
    .mode_reserved(rsv), .parity_ctrl(par), .rx_data_invert(inv), .rx_edge_rise(rise));
  // ----
  // Clock, watchdog
  // ----
  initial begin
    forever #25 clock = ~clock;
  end
  initial begin
    #200000;
    err_count++;
    give_verdict();
  end
  // ----
  // Helpers
  // ----
  function automatic logic [15:0] exp_reg(int i, logic [15:0] v);
    return (v & wm[i]) | one[i];
  endfunction
  function automatic int exp_ticks(int n, int q);
    return n / (q + 1);
  endfunction
  task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Write held through one edge, then one idle edge
  task automatic wr(logic [19:0] a, logic [15:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rdc(logic [19:0] a, logic [15:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    chk("reg_rdata", e, reg_rdata);
  endtask
  task automatic wait_go(output logic s);
    s = 1'b0;
    repeat (10) begin
      @(posedge clock);
      s = s | go[1];
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ----
  // Tests
  // ----
  initial begin
    arst_n <= 1'b0;
    void'($urandom(55));
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    repeat (4) @(posedge clock);
    for (int i = 0; i < 8; i++) rdc(adr[i], i[1] ? 16'h0087 : 16'h0020);
    wr(20'hF0110, 16'hFFFF);
    rdc(20'hF0110, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      d = 16'($urandom);
      wr(adr[i], d);
      rdc(adr[i], exp_reg(i, d));
    end
    $display("test registers done");
    for (int k = 0; k < 4; k++) begin
      wr(adr[0], 16'h0020 | 16'(k << 1));
      wr(adr[2], 16'(k << 14) | 16'(k << 8) | 16'h0007);
      chk("protocol_mode", 16'(k), {14'h0, pm[1:0]});
      chk("mode_reserved", 16'(k == 3), {15'h0, rsv[0]});
      chk("enables", 16'(k), {14'h0, txe[0], rxe[0]});
      chk("parity_ctrl", 16'(k == 1), {14'h0, par[1:0]});
    end
    wr(adr[0], 16'h0022);
    for (int p = 0; p < 4; p++) begin
      wr(adr[2], 16'(p << 8) | 16'h0007);
      chk("parity_ctrl", 16'(p), {14'h0, par[1:0]});
    end
    $display("test modes done");
    for (int b = 0; b < 2; b++) begin
      wr(adr[0], 16'h0022 | 16'(b));
      xend[0] <= 1'b1;
      #1 chk("irq_end", 16'(b == 0), {15'h0, irq[0]});
      @(posedge clock);
      xend[0] <= 1'b0;
      bload[0] <= 1'b1;
      #1 chk("irq_load", 16'(b), {15'h0, irq[0]});
      @(posedge clock);
      bload[0] <= 1'b0;
    end
    // Running channel refuses rewrites but bit 0
    run[0] <= 1'b1;
    wr(adr[0], 16'hC004);
    rdc(adr[0], 16'h0022);
    wr(adr[2], 16'hC000);
    rdc(adr[2], 16'h0307);
    start[0] <= 1'b1;
    @(posedge clock);
    start[0] <= 1'b0;
    #1 chk("start_go", 16'h0001, {15'h0, go[0]});
    @(posedge clock);
    run[0] <= 1'b0;
    $display("test channel 0 done");
    // Edge trigger with inverted receive polarity
    wr(adr[1], 16'h0162);
    chk("rx_invert", 16'h0003, {14'h0, inv, rise});
    rx_pin <= 1'b0;
    run[1] <= 1'b1;
    start[1] <= 1'b1;
    @(posedge clock);
    start[1] <= 1'b0;
    wait_go(seen);
    chk("go_no_edge", 16'h0000, {15'h0, seen});
    rx_pin <= 1'b1;
    wait_go(seen);
    chk("go_on_edge", 16'h0001, {15'h0, seen});
    run[1] <= 1'b0;
    $display("test trigger done");
    // Divider from each prescaler, then pin clock
    r = rat[$urandom % 6];
    div[20:14] <= 7'(r);
    for (int s = 0; s < 3; s++) begin
      wr(adr[4], (s == 2) ? 16'h4020 : 16'h0020 | 16'(s << 15));
      run[2] <= 1'b1;
      cnt = 0;
      for (int c = 0; c < 100; c++) begin
        pa[1] <= c < 96 && c % 2 == 0;
        pb[1] <= c < 96 && c % 4 == 0;
        pin[2] <= c < 80 && c % 16 >= 8;
        @(posedge clock);
        cnt += int'(xt[2]);
      end
      run[2] <= 1'b0;
      chk("xfer_ticks", 16'(s == 2 ? 5 : exp_ticks(s ? 24 : 48, r)), 16'(cnt));
    end
    $display("test divider done");
    give_verdict();
  end
endmodule

bind serial_channel_mode_config serial_channel_mode_config_properties u_props (
  .clock(clock), .arst_n(arst_n), .channel_running_flag(channel_running_flag),
  .channel_start_pulse(channel_start_pulse), .xfer_end_event(xfer_end_event),
  .buffer_load_event(buffer_load_event), .xfer_tick(xfer_tick), .start_go(start_go),
  .channel_irq(channel_irq), .tx_enable(tx_enable), .rx_enable(rx_enable),
  .protocol_mode(protocol_mode), .mode_reserved(mode_reserved), .parity_ctrl(parity_ctrl),
  .rx_data_invert(rx_data_invert), .rx_edge_rise(rx_edge_rise));

/* xfer_clock_divider.v */
// Transfer clock enable generator: divides operating clock ticks.
// Assumes op_tick is a one-cycle pulse on the same clock.
`timescale 1ns/1ps
module xfer_clock_divider (
  input wire clock,
  input wire arst_n,
  input wire run,
  input wire op_tick,
  input wire [6:0] ratio,
  output reg xfer_tick
);
  // ----------------------------------------
  // Divider counter
  // ----------------------------------------
  reg [6:0] count_q; // Ticks counted so far

  // Count ratio+1 op ticks per output pulse
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      count_q <= 7'h00;
      xfer_tick <= 1'b0;
    end else if (!run) begin
      count_q <= 7'h00;
      xfer_tick <= 1'b0;
    end else if (op_tick) begin
      if (count_q >= ratio) begin // see RULE_22
        count_q <= 7'h00;
        xfer_tick <= 1'b1;
      end else begin
        count_q <= count_q + 7'h01;
        xfer_tick <= 1'b0;
      end
    end else begin
      xfer_tick <= 1'b0;
    end
  end
endmodule
